// *** rtl/aecvc_map.svh ***
// Operation
// RL1 - Read-only five-bit first-error pointer, bit position of first uncorrectable error, resets zero.
// RL2 - Bit 5 read-only, resets one: end-to-end CRC generation capable.
// RL3 - Bit 6 writable, resets zero: enables CRC generation; clear means none generated.
// RL4 - Bit 7 read-only, resets one: end-to-end CRC check capable.
// RL5 - Bit 8 writable, resets zero: enables CRC checking of received packets.
// RL6 - Four read-only words hold captured header bits 0..127, big-endian bytes.
// RL7 - Channel capability header low sixteen bits read constant 0002h.
// RL8 - Header bits 19..16 read capability version 1h.
// RL9 - Header bits 31..20 read next-capability pointer 20Ch.
// RL10 - Bits 2..0 read-only extended channel count, resets 000b.
// RL11 - Channel count defaults overridable by management port or EEPROM load.
// RL12 - Bits 6..4 read-only low-priority extended channel count, resets 000b.
// RL13 - Bits 9..8 read reference clock code 00b, meaning 100 ns.
// RL14 - Bits 11..10 always read 10b: four-bit table entries.
// RL15 - Arbitration capability byte reads 00h with zero extended channels, 03h with one.
// RL16 - Bits 31..24 table offset in sixteen-byte units: 00h or 03h likewise.
// RL17 - Writing one to control bit 0 loads the table; bit reads zero.
// RL18 - Three-bit select accepts 0 and 1; other values act as default.
// RL19 - Table status flag bit 16 sets whenever software writes a table entry.
// RL20 - Status flag clears once hardware finishes loading after a load request.
// RL21 - Masked correctable errors neither update header capture nor send a message.
// RL22 - Capture and pointer update only on first unmasked error, held until cleared.
`ifndef AECVC_MAP_SVH
`define AECVC_MAP_SVH
`define AECVC_OFS_AER_CTRL     12'h118
`define AECVC_OFS_HDR0         12'h11C
`define AECVC_OFS_HDR1         12'h120
`define AECVC_OFS_HDR2         12'h124
`define AECVC_OFS_HDR3         12'h128
`define AECVC_OFS_VC_HDR       12'h140
`define AECVC_OFS_PVC_CAP1     12'h144
`define AECVC_OFS_PVC_CAP2     12'h148
`define AECVC_OFS_PVC_CTRL     12'h14C
`define AECVC_BIT_GEN_CAP      5
`define AECVC_BIT_GEN_EN       6
`define AECVC_BIT_CHK_CAP      7
`define AECVC_BIT_CHK_EN       8
`define AECVC_BIT_LOAD         0
`define AECVC_BIT_TBL_STAT     16
`define AECVC_CAP_ID           16'h0002
`define AECVC_CAP_VER          4'h1
`define AECVC_NEXT_PTR         12'h20C
`define AECVC_REF_CLK          2'h0
`define AECVC_ENTRY_SIZE       2'h2
`define AECVC_ARB_CAP_ONE      8'h03
`define AECVC_TBL_OFS_ONE      8'h03
`define AECVC_LOAD_TIME_NS     800
`define AECVC_CLK_PERIOD_NS    100
`define AECVC_LOAD_CYCLES      ((`AECVC_LOAD_TIME_NS + `AECVC_CLK_PERIOD_NS - 1) / `AECVC_CLK_PERIOD_NS)
`endif

// *** rtl/aecvc_pkg.sv ***
`default_nettype none
package aecvc_pkg;
    // Configuration access from the port's config logic
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } aecvc_cfg_req_t;

    // Error event with its packet header
    typedef struct packed {
        logic         valid;
        logic         correctable;
        logic [4:0]   bit_pos;
        logic         masked;
        logic [127:0] header;
    } aecvc_err_evt_t;

    // Load sequencer states
    typedef enum logic [2:0] {
        AECVC_IDLE = 3'b001,
        AECVC_LOAD = 3'b010,
        AECVC_DONE = 3'b100
    } aecvc_load_st_t;
endpackage
`default_nettype wire

// *** rtl/aecvc_table_loader.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "aecvc_map.svh"
module aecvc_table_loader #(
    parameter int LOAD_CYCLES = `AECVC_LOAD_CYCLES
) (
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    input  wire logic start_in,
    output logic      busy_out,
    output logic      done_out
);
    import aecvc_pkg::*;

    aecvc_load_st_t state_reg;
    logic [15:0]    count_reg;

    // Sequencer copying stored table values into the arbiter
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= AECVC_IDLE;
            count_reg <= 16'h0000;
        end
        else
        begin
            case (state_reg)
                AECVC_IDLE:
                begin
                    if (start_in)
                    begin
                        state_reg <= AECVC_LOAD; // RL17
                        count_reg <= 16'h0000;
                    end
                end
                AECVC_LOAD:
                begin
                    if (count_reg == 16'(LOAD_CYCLES - 1))
                        state_reg <= AECVC_DONE;
                    else
                        count_reg <= count_reg + 16'h0001;
                end
                AECVC_DONE:
                    state_reg <= AECVC_IDLE;
                default:
                    state_reg <= AECVC_IDLE;
            endcase
        end
    end

    // Handshake outputs
    assign busy_out = (state_reg == AECVC_LOAD);
    assign done_out = (state_reg == AECVC_DONE);

    // Done follows start within 20 cycles
    load_bound_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL17 RL20
        (start_in && state_reg == AECVC_IDLE) |-> ##[1:20] done_out)
        else $error("table load did not finish");
endmodule
`default_nettype wire

// *** rtl/aecvc_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "aecvc_map.svh"
module aecvc_regs #(
    parameter int LOAD_CYCLES = `AECVC_LOAD_CYCLES
) (
    input  wire logic                     clock_in,
    input  wire logic                     rst_n_in,
    input  wire aecvc_pkg::aecvc_cfg_req_t cfg_req_in,
    output logic [31:0]                   cfg_rdata_out,
    output logic                          cfg_ack_out,
    input  wire aecvc_pkg::aecvc_err_evt_t err_evt_in,
    input  wire logic                     err_status_clear_in,
    output logic                          err_msg_out,
    input  wire logic                     dflt_load_in,
    input  wire logic [2:0]               dflt_ext_count_in,
    input  wire logic [2:0]               dflt_lp_count_in,
    input  wire logic                     arb_table_write_in,
    output logic                          ecrc_gen_en_out,
    output logic                          ecrc_chk_en_out,
    output logic [2:0]                    arb_select_out,
    output logic                          table_load_busy_out
);
    import aecvc_pkg::*;

    logic [4:0]   first_ptr_reg;
    logic         gen_en_reg;
    logic         chk_en_reg;
    logic [127:0] header_reg;
    logic         logged_reg;
    logic [2:0]   ext_count_reg;
    logic [2:0]   lp_count_reg;
    logic [2:0]   arb_sel_reg;
    logic         tbl_stat_reg;
    logic [31:0]  rdata_reg;
    logic         ack_reg;
    logic         msg_reg;
    logic         load_start;
    logic         load_done;
    logic         wr_ctrl;
    logic         wr_aer;
    logic         take_err;
    logic         sel_fold_hit;
    logic [31:0]  rdata_next;
    logic [31:0]  hdr_word [4];
    logic [31:0]  hdr_rd_word;

    // Write decodes
    assign wr_aer     = cfg_req_in.wr && (cfg_req_in.addr == `AECVC_OFS_AER_CTRL);
    assign wr_ctrl    = cfg_req_in.wr && (cfg_req_in.addr == `AECVC_OFS_PVC_CTRL);
    assign load_start = wr_ctrl && cfg_req_in.be[0] && cfg_req_in.wdata[`AECVC_BIT_LOAD]; // RL17
    assign sel_fold_hit = wr_ctrl && cfg_req_in.be[0] && (cfg_req_in.wdata[3:1] > 3'h1); // RL18
    assign take_err   = err_evt_in.valid && !err_evt_in.masked && (!logged_reg || err_status_clear_in); // RL21 RL22

    // CRC enables
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            gen_en_reg <= 1'b0;
            chk_en_reg <= 1'b0;
        end
        else
        begin
            if (wr_aer && cfg_req_in.be[0])
                gen_en_reg <= cfg_req_in.wdata[`AECVC_BIT_GEN_EN]; // RL3
            if (wr_aer && cfg_req_in.be[1])
                chk_en_reg <= cfg_req_in.wdata[`AECVC_BIT_CHK_EN]; // RL5
        end
    end

    // First-error capture and header log
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            first_ptr_reg <= 5'h00;
            header_reg    <= 128'h0;
            logged_reg    <= 1'b0;
        end
        else if (take_err)
        begin
            header_reg <= err_evt_in.header; // RL6 RL22
            logged_reg <= 1'b1;
            if (!err_evt_in.correctable)
                first_ptr_reg <= err_evt_in.bit_pos; // RL1
        end
        else if (err_status_clear_in)
        begin
            logged_reg <= 1'b0; // RL22
        end
    end

    // Error message only for unmasked events
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            msg_reg <= 1'b0;
        else
            msg_reg <= err_evt_in.valid && !err_evt_in.masked; // RL21
    end

    // Channel count defaults from serial port or EEPROM
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ext_count_reg <= 3'h0; // RL10
            lp_count_reg  <= 3'h0; // RL12
        end
        else if (dflt_load_in)
        begin
            ext_count_reg <= dflt_ext_count_in; // RL11
            lp_count_reg  <= dflt_lp_count_in;  // RL11
        end
    end

    // Arbitration select with illegal values folded to default
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            arb_sel_reg <= 3'h0;
        else if (wr_ctrl && cfg_req_in.be[0])
            arb_sel_reg <= (cfg_req_in.wdata[3:1] <= 3'h1) ? cfg_req_in.wdata[3:1] : 3'h0; // RL18
    end

    // Table status: set on entry write wins over loader clear
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            tbl_stat_reg <= 1'b0;
        else if (arb_table_write_in)
            tbl_stat_reg <= 1'b1; // RL19
        else if (load_done)
            tbl_stat_reg <= 1'b0; // RL20
    end

    aecvc_table_loader #(
        .LOAD_CYCLES (LOAD_CYCLES)
    ) u_loader (
        .clock_in (clock_in),
        .rst_n_in (rst_n_in),
        .start_in (load_start),
        .busy_out (table_load_busy_out),
        .done_out (load_done)
    );

    // Header capture words, each picked by its own offset
    for (genvar gi = 0; gi < 4; gi++)
    begin : g_hdr_word
        assign hdr_word[gi] = (cfg_req_in.addr == 12'(`AECVC_OFS_HDR0 + 4 * gi))
                              ? header_reg[32 * gi +: 32] : 32'h0000_0000; // RL6
    end

    // Only one word can match, so an OR selects it
    assign hdr_rd_word = hdr_word[0] | hdr_word[1] | hdr_word[2] | hdr_word[3];

    // Read mux
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (cfg_req_in.addr)
            `AECVC_OFS_AER_CTRL:
            begin
                rdata_next[4:0]                = first_ptr_reg; // RL1
                rdata_next[`AECVC_BIT_GEN_CAP] = 1'b1;          // RL2
                rdata_next[`AECVC_BIT_GEN_EN]  = gen_en_reg;
                rdata_next[`AECVC_BIT_CHK_CAP] = 1'b1;          // RL4
                rdata_next[`AECVC_BIT_CHK_EN]  = chk_en_reg;
            end
            `AECVC_OFS_HDR0, `AECVC_OFS_HDR1, `AECVC_OFS_HDR2, `AECVC_OFS_HDR3:
                rdata_next = hdr_rd_word; // RL6
            `AECVC_OFS_VC_HDR:
                rdata_next = {`AECVC_NEXT_PTR, `AECVC_CAP_VER, `AECVC_CAP_ID}; // RL7 RL8 RL9
            `AECVC_OFS_PVC_CAP1:
            begin
                rdata_next[2:0]   = ext_count_reg;     // RL10
                rdata_next[6:4]   = lp_count_reg;      // RL12
                rdata_next[9:8]   = `AECVC_REF_CLK;    // RL13
                rdata_next[11:10] = `AECVC_ENTRY_SIZE; // RL14
            end
            `AECVC_OFS_PVC_CAP2:
            begin
                if (ext_count_reg != 3'h0)
                begin
                    rdata_next[7:0]   = `AECVC_ARB_CAP_ONE; // RL15
                    rdata_next[31:24] = `AECVC_TBL_OFS_ONE; // RL16
                end
            end
            `AECVC_OFS_PVC_CTRL:
            begin
                rdata_next[3:1]                 = arb_sel_reg;  // RL17 RL18
                rdata_next[`AECVC_BIT_TBL_STAT] = tbl_stat_reg;
            end
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // Registered read answer
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rdata_reg <= 32'h0000_0000;
            ack_reg   <= 1'b0;
        end
        else
        begin
            rdata_reg <= cfg_req_in.rd ? rdata_next : 32'h0000_0000;
            ack_reg   <= cfg_req_in.rd || cfg_req_in.wr;
        end
    end

    assign cfg_rdata_out   = rdata_reg;
    assign cfg_ack_out     = ack_reg;
    assign err_msg_out     = msg_reg;
    assign ecrc_gen_en_out = gen_en_reg;
    assign ecrc_chk_en_out = chk_en_reg;
    assign arb_select_out  = arb_sel_reg;

    // Control write checks
    gen_gate_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL3
        (wr_aer && cfg_req_in.be[0]) |=> (ecrc_gen_en_out == $past(cfg_req_in.wdata[`AECVC_BIT_GEN_EN])))
        else $error("generation enable not written");
    chk_gate_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL5
        (wr_aer && cfg_req_in.be[1]) |=> (ecrc_chk_en_out == $past(cfg_req_in.wdata[`AECVC_BIT_CHK_EN])))
        else $error("check enable not written");
    sel_legal_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL18
        arb_select_out <= 3'h1)
        else $error("illegal arbitration select");
    sel_fold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL18
        (wr_ctrl && cfg_req_in.be[0] && cfg_req_in.wdata[3:1] > 3'h1) |=> (arb_select_out == 3'h0))
        else $error("illegal select not folded to default");

    // Error capture checks
    hdr_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL22
        (logged_reg && !err_status_clear_in) |=> $stable(header_reg))
        else $error("header log overwritten");
    ptr_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL22
        (logged_reg && !err_status_clear_in) |=> $stable(first_ptr_reg))
        else $error("first error pointer overwritten");
    ptr_load_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL1
        (take_err && !err_evt_in.correctable) |=> (first_ptr_reg == $past(err_evt_in.bit_pos)))
        else $error("first error pointer not captured");
    mask_block_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL21
        (err_evt_in.valid && err_evt_in.masked) |=> (!err_msg_out && $stable(header_reg)))
        else $error("masked error acted on");
    msg_send_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL21
        (err_evt_in.valid && !err_evt_in.masked) |=> err_msg_out)
        else $error("unmasked error not signalled");

    // Channel count check
    dflt_take_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL11
        dflt_load_in |=> (ext_count_reg == $past(dflt_ext_count_in) && lp_count_reg == $past(dflt_lp_count_in)))
        else $error("default counts not loaded");

    // Table load and status checks
    stat_set_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL19
        arb_table_write_in |=> tbl_stat_reg)
        else $error("table status not set");
    stat_keep_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL19
        (tbl_stat_reg && !load_done) |=> tbl_stat_reg)
        else $error("table status dropped early");
    stat_clr_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL20
        (load_done && !arb_table_write_in) |=> !tbl_stat_reg)
        else $error("table status not cleared");
    load_go_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL17
        (load_start && !table_load_busy_out && !load_done) |=> table_load_busy_out)
        else $error("table load not started");
    done_prev_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL20
        load_done |-> $past(table_load_busy_out))
        else $error("load finished without loading");

    // Read answer checks
    caps_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL2 RL4
        (cfg_req_in.rd && cfg_req_in.addr == `AECVC_OFS_AER_CTRL)
        |=> (cfg_rdata_out[`AECVC_BIT_GEN_CAP] && cfg_rdata_out[`AECVC_BIT_CHK_CAP]))
        else $error("capability flags read as zero");
    hdr_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL6
        (cfg_req_in.rd && cfg_req_in.addr == `AECVC_OFS_HDR3) |=> (cfg_rdata_out == $past(header_reg[127:96])))
        else $error("header word read wrong");
    vchdr_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL7 RL8 RL9
        (cfg_req_in.rd && cfg_req_in.addr == `AECVC_OFS_VC_HDR) |=> (cfg_rdata_out == 32'h20C1_0002))
        else $error("capability header wrong");
    cap1_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL13 RL14
        (cfg_req_in.rd && cfg_req_in.addr == `AECVC_OFS_PVC_CAP1)
        |=> (cfg_rdata_out[11:8] == {`AECVC_ENTRY_SIZE, `AECVC_REF_CLK}))
        else $error("entry size or reference clock wrong");
    cnt_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL10 RL12
        (cfg_req_in.rd && cfg_req_in.addr == `AECVC_OFS_PVC_CAP1)
        |=> (cfg_rdata_out[2:0] == $past(ext_count_reg) && cfg_rdata_out[6:4] == $past(lp_count_reg)))
        else $error("channel counts read wrong");
    cap2_ofs_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL15 RL16
        (cfg_req_in.rd && cfg_req_in.addr == `AECVC_OFS_PVC_CAP2 && ext_count_reg == 3'h0)
        |=> (cfg_rdata_out == 32'h0000_0000))
        else $error("capability two nonzero without channels");
    cap2_one_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL15 RL16
        (cfg_req_in.rd && cfg_req_in.addr == `AECVC_OFS_PVC_CAP2 && ext_count_reg != 3'h0)
        |=> (cfg_rdata_out == {`AECVC_TBL_OFS_ONE, 16'h0000, `AECVC_ARB_CAP_ONE}))
        else $error("capability two wrong with channels");
    load_read_a: assert property (@(posedge clock_in) disable iff (!rst_n_in) // RL17
        (cfg_req_in.rd && cfg_req_in.addr == `AECVC_OFS_PVC_CTRL) |=> !cfg_rdata_out[0])
        else $error("load bit read as one");

    // Main scenarios
    load_seen_c: cover property (@(posedge clock_in) disable iff (!rst_n_in) load_start ##[1:20] load_done);
    sel_fold_c: cover property (@(posedge clock_in) disable iff (!rst_n_in) sel_fold_hit);
    err_log_c: cover property (@(posedge clock_in) disable iff (!rst_n_in) take_err);
    mask_c: cover property (@(posedge clock_in) disable iff (!rst_n_in) err_evt_in.valid && err_evt_in.masked);
    dflt_c: cover property (@(posedge clock_in) disable iff (!rst_n_in) dflt_load_in && dflt_ext_count_in == 3'h1);
endmodule
`default_nettype wire

// *** sim/aecvc_cfg_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// Configuration software stand-in issuing one-cycle requests
module aecvc_cfg_host (
    input  wire logic                     clock_in,
    output var  aecvc_pkg::aecvc_cfg_req_t req_out
);
    import aecvc_pkg::*;

    initial req_out = '0;

    // One request pulse; address and data held after the strobe drops
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata, input logic [3:0] be);
        @(negedge clock_in);
        req_out.rd    = ~wr;
        req_out.wr    = wr;
        req_out.addr  = addr;
        req_out.wdata = wdata;
        req_out.be    = be;
        @(negedge clock_in);
        req_out.rd    = 1'b0;
        req_out.wr    = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** sim/aer_control_vchan_ext_cap_header_regs_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module aer_control_vchan_ext_cap_header_regs_tb_top;
    import aecvc_pkg::*;
    localparam int LOADS = 4;
    logic           clock_in = 1'b0;
    logic           rst_n_in;
    aecvc_cfg_req_t req;
    aecvc_err_evt_t evt;
    logic [31:0]    rdata;
    logic [31:0]    seed;
    logic [127:0]   hdr;
    logic [4:0]     ptr;
    logic [2:0]     dext;
    logic [2:0]     dlp;
    logic [2:0]     sel;
    logic [32:0]    note;
    logic [32:0]    exp_q[$];
    logic           ack, clr, msg, dload, tbl_wr, gen_en, chk_en, busy;
    int             err_total = 0;
    int             checks_done = 0;
    int             cycles = 0;
    int             busy_cnt = 0;
    int             busy_base = 0;

    aecvc_cfg_host u_aecvc_cfg_host (.clock_in(clock_in), .req_out(req));

    aecvc_regs #(.LOAD_CYCLES(LOADS)) u_aecvc_regs (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .cfg_req_in(req), .cfg_rdata_out(rdata),
        .cfg_ack_out(ack), .err_evt_in(evt), .err_status_clear_in(clr), .err_msg_out(msg),
        .dflt_load_in(dload), .dflt_ext_count_in(dext), .dflt_lp_count_in(dlp),
        .arb_table_write_in(tbl_wr), .ecrc_gen_en_out(gen_en), .ecrc_chk_en_out(chk_en),
        .arb_select_out(sel), .table_load_busy_out(busy));

    // Clock
    always #50 clock_in = ~clock_in;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic tally_and_finish;
        $display("Counts: %0d checks, %0d mismatches", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back({1'b1, e});
        u_aecvc_cfg_host.xfer(1'b0, a, 32'h0000_0000, 4'h0);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
        exp_q.push_back({1'b0, 32'h0000_0000});
        u_aecvc_cfg_host.xfer(1'b1, a, d, b);
    endtask

    task automatic pulse_clear;
        @(negedge clock_in);
        clr = 1'b1;
        @(negedge clock_in);
        clr = 1'b0;
    endtask

    // Error event; message checked in the cycle after it is taken
    task automatic fire(input logic corr, input logic mask, input logic [4:0] pos, input logic [127:0] h,
                        input logic want);
        @(negedge clock_in);
        evt = '{1'b1, corr, pos, mask, h};
        @(negedge clock_in);
        evt.valid = 1'b0;
        check({31'h0, msg}, {31'h0, want});
    endtask

    // Match each acknowledge with the oldest note; count loader busy cycles
    always @(negedge clock_in)
    begin
        if (busy === 1'b1) busy_cnt++;
        if (ack === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(32'h0000_0000, 32'h0000_0001);
            else
            begin
                note = exp_q.pop_front();
                if (note[32]) check(rdata, note[31:0]);
            end
        end
    end

    // Hang guard
    always @(posedge clock_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            err_total++;
            $display("Run cut short at cycle limit");
            tally_and_finish();
        end
    end

    // Main sequence
    initial
    begin
        rst_n_in = 1'b0;
        evt = '0;
        clr = 1'b0;
        dload = 1'b0;
        dext = 3'h0;
        dlp = 3'h0;
        tbl_wr = 1'b0;
        seed = 32'h0000_7981;
        repeat (8) @(negedge clock_in);
        rst_n_in = 1'b1;
        rd(12'h118, 32'h0000_00A0);
        rd(12'h140, 32'h20C1_0002);
        rd(12'h144, 32'h0000_0800);
        rd(12'h148, 32'h0000_0000);
        rd(12'h14C, 32'h0000_0000);
        rd(12'h200, 32'h0000_0000);
        check({30'h0, gen_en, chk_en}, 32'h0000_0000);
        $display("Test reset values done");
        wr(12'h118, 32'hFFFF_FFFF, 4'hF);
        rd(12'h118, 32'h0000_01E0);
        check({30'h0, gen_en, chk_en}, 32'h0000_0003);
        wr(12'h118, 32'h0000_0000, 4'h2);
        rd(12'h118, 32'h0000_00E0);
        check({30'h0, gen_en, chk_en}, 32'h0000_0002);
        $display("Test end-to-end CRC enables done");
        for (int v = 0; v < 8; v++)
        begin
            wr(12'h14C, {28'h0, v[2:0], 1'b0}, 4'h1);
            rd(12'h14C, {28'h0, (v < 2) ? v[2:0] : 3'h0, 1'b0});
            check({29'h0, sel}, (v < 2) ? v : 0);
        end
        $display("Test arbitration select done");
        @(negedge clock_in);
        tbl_wr = 1'b1;
        @(negedge clock_in);
        tbl_wr = 1'b0;
        busy_base = busy_cnt;
        rd(12'h14C, 32'h0001_0000);
        wr(12'h14C, 32'h0000_0003, 4'h1);
        rd(12'h14C, 32'h0001_0002);
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clock_in);
        repeat (2) @(negedge clock_in);
        rd(12'h14C, 32'h0000_0002);
        check(busy_cnt - busy_base, LOADS);
        $display("Test table load done");
        for (int k = 0; k < 4; k++)
        begin
            seed = xs(seed);
            @(negedge clock_in);
            dext = (k == 0) ? 3'h1 : seed[2:0];
            dlp = seed[6:4];
            dload = 1'b1;
            @(negedge clock_in);
            dload = 1'b0;
            rd(12'h144, {20'h0, 4'h8, 1'b0, dlp, 1'b0, dext});
            rd(12'h148, (dext == 3'h0) ? 32'h0000_0000 : 32'h0300_0003);
        end
        $display("Test default override done");
        seed = xs(seed);
        ptr = seed[4:0];
        hdr = {seed, ~seed, seed ^ 32'h5A5A_5A5A, 32'h1234_5678};
        fire(1'b0, 1'b0, ptr, hdr, 1'b1);
        fire(1'b0, 1'b0, ~ptr, ~hdr, 1'b1);
        rd(12'h118, {23'h0, 4'h7, ptr});
        for (int w = 0; w < 4; w++) rd(12'h11C + 12'(4 * w), hdr[32 * w +: 32]);
        pulse_clear();
        fire(1'b1, 1'b1, 5'h00, ~hdr, 1'b0);
        rd(12'h11C, hdr[31:0]);
        fire(1'b1, 1'b0, 5'h00, {hdr[63:0], hdr[127:64]}, 1'b1);
        rd(12'h11C, hdr[95:64]);
        rd(12'h118, {23'h0, 4'h7, ptr});
        repeat (3) @(negedge clock_in);
        check(exp_q.size(), 32'h0000_0000);
        $display("Test error capture done");
        @(negedge clock_in);
        rst_n_in = 1'b0;
        repeat (2) @(negedge clock_in);
        rst_n_in = 1'b1;
        rd(12'h118, 32'h0000_00A0);
        rd(12'h144, 32'h0000_0800);
        rd(12'h14C, 32'h0000_0000);
        check({29'h0, sel}, 32'h0000_0000);
        check({30'h0, gen_en, chk_en}, 32'h0000_0000);
        repeat (3) @(negedge clock_in);
        check(exp_q.size(), 32'h0000_0000);
        $display("Test mid-run reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
